/* hw/oneshot_pwm_pkg.sv */
// Shared constants and helpers for the sawtooth one-shot pulse channel
package oneshot_pwm_pkg;

    // Count clock and carrier timing
    localparam int unsigned CLOCK_PERIOD_NS   = 50;
    localparam int unsigned CARRIER_PERIOD_NS = 1_000_000;
    localparam int unsigned CARRIER_CYCLES    = CARRIER_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int unsigned PERIOD_RESET      = CARRIER_CYCLES - 1;

    // Counter width and reset values
    localparam int unsigned COUNT_WIDTH  = 32;
    localparam logic [31:0] COUNT_INIT   = 32'h0000_0000;
    localparam logic [31:0] COMPARE_INIT = 32'h0000_0000;

    // Force-duty field codes
    typedef enum logic [1:0] {
        force_off_t  = 2'h0,
        force_off2_t = 2'h1,
        force_low_t  = 2'h2,
        force_high_t = 2'h3
    } force_duty_t;
    localparam logic [1:0] FORCE_DUTY_RESET = 2'h0;

    // Cycle-end output function field (bits [3:2] of the io function)
    localparam int unsigned END_FN_LSB = 2;
    localparam int unsigned END_FN_MSB = 3;
    localparam logic [1:0] END_RETAIN = 2'h0;
    localparam logic [1:0] END_LOW    = 2'h1;
    localparam logic [1:0] END_HIGH   = 2'h2;
    localparam logic [1:0] END_TOGGLE = 2'h3;

    // Initial pin levels at count start
    localparam logic OUT_A_INIT = 1'b0;
    localparam logic OUT_B_INIT = 1'b1;

    // Level after the cycle-end function is applied
    function automatic logic cycle_end_level(input logic [1:0] fn, input logic level);
        unique case (fn)
            END_RETAIN: cycle_end_level = level;
            END_LOW:    cycle_end_level = 1'b0;
            END_HIGH:   cycle_end_level = 1'b1;
            END_TOGGLE: cycle_end_level = ~level;
        endcase
    endfunction

    // True when the force-duty code holds the pin
    function automatic logic is_forced(input logic [1:0] code);
        is_forced = code[1];
    endfunction

endpackage : oneshot_pwm_pkg

/* hw/sawtooth_counter.sv */
// Up-counting sawtooth counter with overflow at the period value
`timescale 1ns/100ps
`default_nettype none
module sawtooth_counter
    import oneshot_pwm_pkg::*;
#(
    parameter int unsigned CW = COUNT_WIDTH
) (
    input  wire logic          clock,     // Count clock
    input  wire logic          rst_n,     // Sync reset, active low
    input  wire logic          start,     // Count-start pulse
    input  wire logic          stop,      // Count-stop pulse
    input  wire logic [CW-1:0] period,    // Period value
    output logic               running,   // Counter active
    output logic [CW-1:0]      count,     // Current count
    output logic               overflow   // Count at or above period while running this cycle
);
    logic          running_q;
    logic [CW-1:0] count_q;

    // Run flag; stop wins so a stuck start cannot defeat it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            running_q <= 1'b0;
        end else if (stop) begin
            running_q <= 1'b0;
        end else if (start) begin
            running_q <= 1'b1;
        end
    end

    // Count from zero up to period, then wrap
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q <= CW'(COUNT_INIT);
        end else if (start && !running_q) begin
            count_q <= CW'(COUNT_INIT);
        end else if (running_q) begin
            if (count_q >= period) begin
                count_q <= CW'(COUNT_INIT);
            end else begin
                count_q <= count_q + CW'(1);
            end
        end
    end

    assign running  = running_q;
    assign count    = count_q;
    assign overflow = running_q && (count_q >= period);

endmodule // sawtooth_counter
`default_nettype wire

/* hw/pwm_output_stage.sv */
// One pin: toggle on match, cycle-end function, forced duty with release
`timescale 1ns/100ps
`default_nettype none
module pwm_output_stage
    import oneshot_pwm_pkg::*;
#(
    parameter logic INIT_LEVEL = 1'b0
) (
    input  wire logic       clock,       // Count clock
    input  wire logic       rst_n,       // Sync reset, active low
    input  wire logic       start,       // Count start, loads initial level
    input  wire logic       overflow,    // Cycle end
    input  wire logic       match,       // Compare match
    input  wire logic [1:0] force_duty,  // Requested force-duty code
    input  wire logic       release_sel, // Release from masked match value
    input  wire logic [1:0] end_fn,      // Cycle-end output function
    input  wire logic       pin_enable,  // Pin assigned to the timer
    output logic            pin          // Registered pin level
);
    logic [1:0] active_q;  // Force code in effect this cycle
    logic       cmp_q;     // Compare-driven level, runs on while forced
    logic       pin_q;
    logic       forced_now;
    logic       level;

    assign forced_now = is_forced(active_q);
    assign level = !forced_now ? cmp_q : active_q[0];

    // Force code takes effect only at a period boundary or at count start
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_q <= FORCE_DUTY_RESET;
        end else if (overflow || start) begin
            active_q <= force_duty;
        end
    end

    // Match beats cycle end; tracking continues under forcing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmp_q <= INIT_LEVEL;
        end else if (start) begin
            cmp_q <= INIT_LEVEL;
        end else if (match) begin
            cmp_q <= ~cmp_q;
        end else if (overflow && forced_now && !is_forced(force_duty) && !release_sel) begin
            cmp_q <= cycle_end_level(end_fn, active_q[0]);
        end else if (overflow) begin
            cmp_q <= cycle_end_level(end_fn, cmp_q);
        end
    end

    // Pin shows the level once routed to the timer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_enable ? level : 1'b0;
        end
    end

    assign pin = pin_q;

endmodule // pwm_output_stage
`default_nettype wire

/* hw/sawtooth_oneshot_pulse_pwm.sv */
// Timer channel in sawtooth one-shot pulse mode with auto dead time
`timescale 1ns/100ps
`default_nettype none
module sawtooth_oneshot_pulse_pwm
    import oneshot_pwm_pkg::*;
#(
    parameter int unsigned CW           = COUNT_WIDTH,
    parameter int unsigned PERIOD_INIT  = PERIOD_RESET
) (
    input  wire logic          clock,                // 20 MHz count clock
    input  wire logic          rst_n,                // Sync reset, active low
    input  wire logic          count_start,          // Software count start pulse
    input  wire logic          count_stop,           // Software count stop pulse
    input  wire logic          forced_transfer,      // Forced buffer transfer pulse
    input  wire logic          period_wr,            // Period write strobe
    input  wire logic [CW-1:0] period_wdata,         // Period write data
    input  wire logic          buffer_c_wr,          // Buffer C write strobe
    input  wire logic [CW-1:0] buffer_c_wdata,       // Buffer C write data
    input  wire logic          buffer_d_wr,          // Buffer D write strobe
    input  wire logic [CW-1:0] buffer_d_wdata,       // Buffer D write data
    input  wire logic          compare_b_wr,         // Direct compare B write
    input  wire logic [CW-1:0] compare_b_wdata,      // Compare B write data
    input  wire logic          dead_time_enable,     // Automatic dead time on
    input  wire logic [CW-1:0] dead_time_up_value,   // Dead time before first edge
    input  wire logic [CW-1:0] dead_time_down_value, // Dead time after second edge
    input  wire logic [1:0]    out_a_force_duty,     // Force-duty code, output A
    input  wire logic [1:0]    out_b_force_duty,     // Force-duty code, output B
    input  wire logic          out_a_release_select, // Release source, output A
    input  wire logic          out_b_release_select, // Release source, output B
    input  wire logic [3:0]    out_a_io_function,    // Io function, output A
    input  wire logic [3:0]    out_b_io_function,    // Io function, output B
    input  wire logic          pin_mode_select_a,    // Pin A given to timer
    input  wire logic          pin_mode_select_b,    // Pin B given to timer
    output logic               pwm_output_a,         // PWM pin A
    output logic               pwm_output_b,         // PWM pin B
    output logic               overflow_interrupt,   // Overflow pulse
    output logic               compare_a_event,      // Compare A match pulse
    output logic               compare_b_event,      // Compare B match pulse
    output logic               counting,             // Counter running
    output logic [CW-1:0]      channel_counter,      // Count, one cycle late
    output logic [CW-1:0]      compare_a,            // Compare A value
    output logic [CW-1:0]      compare_b             // Compare B value
);
    import oneshot_pwm_pkg::*;

    // Dead-time adjusted compare B value; wraps at the full counter width, not at the period
    function automatic logic [CW-1:0] dead_edge(input logic [CW-1:0] base,
                                                input logic [CW-1:0] dt,
                                                input logic          after);
        dead_edge = after ? base + dt : base - dt;
    endfunction

    // Software-visible registers
    logic [CW-1:0] period_q;
    logic [CW-1:0] buffer_c_q;
    logic [CW-1:0] buffer_d_q;
    logic [CW-1:0] temp_a_q;
    logic [CW-1:0] compare_a_q;
    logic [CW-1:0] compare_b_q;

    // Registered views
    logic          ovf_irq_q;
    logic          cmp_a_evt_q;
    logic          cmp_b_evt_q;
    logic          counting_q;
    logic [CW-1:0] count_view_q;

    // Counter interface
    logic          running;
    logic [CW-1:0] count;
    logic          overflow;
    logic          start_event;

    // Match decode
    logic          match_a;
    logic          match_b;
    logic          load_from_buffers;
    logic          load_from_temp;

    assign start_event = count_start && !running;

    sawtooth_counter #(
        .CW       (CW)
    ) u_counter (
        .clock    (clock),
        .rst_n    (rst_n),
        .start    (count_start),
        .stop     (count_stop),
        .period   (period_q),
        .running  (running),
        .count    (count),
        .overflow (overflow)
    );

    // Matches are only meaningful while counting
    assign match_a = running && (count == compare_a_q);
    assign match_b = running && (count == compare_b_q);

    // Overflow or forced transfer reloads from the buffers
    assign load_from_buffers = overflow || forced_transfer;
    // Second edge reload; an overflow in the same cycle starts a new period
    assign load_from_temp = match_a && !load_from_buffers;

    // Period register; the software keeps it above the compare values
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            period_q <= CW'(PERIOD_INIT);
        end else if (period_wr) begin
            period_q <= period_wdata;
        end
    end

    // Buffer C and D hold the next period's edges
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            buffer_c_q <= CW'(COMPARE_INIT);
        end else if (buffer_c_wr) begin
            buffer_c_q <= buffer_c_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            buffer_d_q <= CW'(COMPARE_INIT);
        end else if (buffer_d_wr) begin
            buffer_d_q <= buffer_d_wdata;
        end
    end

    // Temporary A keeps the second edge until match A calls for it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            temp_a_q <= CW'(COMPARE_INIT);
        end else if (load_from_buffers) begin
            temp_a_q <= buffer_d_q;
        end
    end

    // Compare A: first edge from C, second edge from temporary A
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_a_q <= CW'(COMPARE_INIT);
        end else if (load_from_buffers) begin
            compare_a_q <= buffer_c_q;
        end else if (load_from_temp) begin
            compare_a_q <= temp_a_q;
        end
    end

    // Compare B follows compare A with dead time, else software writes it.
    // B leads the first edge and trails the second, widening its low phase.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_b_q <= CW'(COMPARE_INIT);
        end else if (dead_time_enable) begin
            if (load_from_buffers) begin
                compare_b_q <= dead_edge(buffer_c_q, dead_time_up_value, 1'b0);
            end else if (load_from_temp) begin
                compare_b_q <= dead_edge(temp_a_q, dead_time_down_value, 1'b1);
            end
        end else if (compare_b_wr) begin
            compare_b_q <= compare_b_wdata;
        end
    end

    // Output A: low at start, toggling on match A
    pwm_output_stage #(
        .INIT_LEVEL  (OUT_A_INIT)
    ) u_out_a (
        .clock       (clock),
        .rst_n       (rst_n),
        .start       (start_event),
        .overflow    (overflow),
        .match       (match_a),
        .force_duty  (out_a_force_duty),
        .release_sel (out_a_release_select),
        .end_fn      (out_a_io_function[END_FN_MSB:END_FN_LSB]),
        .pin_enable  (pin_mode_select_a),
        .pin         (pwm_output_a)
    );

    // Output B: high at start, toggling on match B
    pwm_output_stage #(
        .INIT_LEVEL  (OUT_B_INIT)
    ) u_out_b (
        .clock       (clock),
        .rst_n       (rst_n),
        .start       (start_event),
        .overflow    (overflow),
        .match       (match_b),
        .force_duty  (out_b_force_duty),
        .release_sel (out_b_release_select),
        .end_fn      (out_b_io_function[END_FN_MSB:END_FN_LSB]),
        .pin_enable  (pin_mode_select_b),
        .pin         (pwm_output_b)
    );

    // Overflow interrupt, one cycle per wrap
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= overflow;
        end
    end

    // Compare events keep firing under forced duty
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmp_a_evt_q <= 1'b0;
            cmp_b_evt_q <= 1'b0;
        end else begin
            cmp_a_evt_q <= match_a;
            cmp_b_evt_q <= match_b;
        end
    end

    // Status views, registered so every output is a flop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            counting_q   <= 1'b0;
            count_view_q <= CW'(COUNT_INIT);
        end else begin
            counting_q   <= running;
            count_view_q <= count;
        end
    end

    assign overflow_interrupt = ovf_irq_q;
    assign compare_a_event    = cmp_a_evt_q;
    assign compare_b_event    = cmp_b_evt_q;
    assign counting           = counting_q;
    assign channel_counter    = count_view_q;
    assign compare_a          = compare_a_q;
    assign compare_b          = compare_b_q;

endmodule // sawtooth_oneshot_pulse_pwm
`default_nettype wire

/* bench/oneshot_pwm_properties.sv */
// Port-level checker for the sawtooth one-shot pulse channel
`timescale 1ns/100ps
`default_nettype none
module oneshot_pwm_properties #(
    parameter int unsigned CW = 32
) (
    input wire logic          clock,                // Clock
    input wire logic          rst_n,                // Reset
    input wire logic          count_start,          // Start
    input wire logic          dead_time_enable,     // Dead time on
    input wire logic [CW-1:0] dead_time_up_value,   // Lead gap
    input wire logic [CW-1:0] dead_time_down_value, // Trail gap
    input wire logic [1:0]    out_a_force_duty,     // Force A
    input wire logic [1:0]    out_b_force_duty,     // Force B
    input wire logic          pin_mode_select_a,    // Pin A routed
    input wire logic          pin_mode_select_b,    // Pin B routed
    input wire logic          pwm_output_a,         // Pin A
    input wire logic          pwm_output_b,         // Pin B
    input wire logic          overflow_interrupt,   // Overflow
    input wire logic          compare_a_event,      // Match A
    input wire logic          counting,             // Running
    input wire logic [CW-1:0] channel_counter,      // Count
    input wire logic [CW-1:0] compare_a,            // Compare A
    input wire logic [CW-1:0] compare_b             // Compare B
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Overflow seen while running, and the early part of a forced period
    sequence wrap_s;
        counting && overflow_interrupt;
    endsequence
    sequence hold_a_s;
        (pwm_output_a == out_a_force_duty[0]) [*3];
    endsequence
    sequence hold_b_s;
        (pwm_output_b == out_b_force_duty[0]) [*3];
    endsequence

    count_step_a: assert property (
        counting && $past(counting) && !$past(overflow_interrupt)
        |-> channel_counter == $past(channel_counter) + 1) else $error("Count did not step by one");
    ovf_wrap_a: assert property (
        wrap_s |=> channel_counter == '0) else $error("Count did not wrap to zero");
    wrap_irq_a: assert property (
        counting && $past(counting) && channel_counter == '0 && $past(channel_counter) != '0
        |-> $past(overflow_interrupt)) else $error("Wrap without overflow pulse");
    match_dt_a: assert property (
        compare_a_event && !overflow_interrupt && dead_time_enable && $past(dead_time_enable)
        |-> compare_b == compare_a + dead_time_down_value) else $error("Compare B wrong after match");
    load_dt_a: assert property (
        overflow_interrupt && dead_time_enable && $past(dead_time_enable)
        |-> compare_b == compare_a - dead_time_up_value) else $error("Compare B wrong after load");
    force_hold_a: assert property (
        wrap_s ##0 (out_a_force_duty[1] && pin_mode_select_a) |=> hold_a_s) else $error("Pin A not forced");
    force_hold_b_a: assert property (
        wrap_s ##0 (out_b_force_duty[1] && pin_mode_select_b) |=> hold_b_s) else $error("Pin B not forced");
    pin_off_a: assert property (
        !pin_mode_select_a && !$past(pin_mode_select_a) |-> !pwm_output_a) else $error("Unrouted pin driven");
    start_only_a: assert property (
        !counting && !count_start && !$past(count_start) |=> !counting) else $error("Counter ran unasked");
endmodule // oneshot_pwm_properties

bind sawtooth_oneshot_pulse_pwm oneshot_pwm_properties #(.CW(CW)) oneshot_pwm_properties_i (
    .clock, .rst_n, .count_start, .dead_time_enable, .dead_time_up_value, .dead_time_down_value,
    .out_a_force_duty, .out_b_force_duty, .pin_mode_select_a, .pin_mode_select_b, .pwm_output_a,
    .pwm_output_b, .overflow_interrupt, .compare_a_event, .counting, .channel_counter, .compare_a, .compare_b);
`default_nettype wire

/* bench/power_stage_model.sv */
// Half-bridge model integrating gate-on time and shoot-through
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
    input  wire logic clock,   // Clock
    input  wire logic rst_n,   // Reset
    input  wire logic gate_a,  // Upper gate
    input  wire logic gate_b,  // Lower gate
    output var  int   high_a,  // Upper on-cycles
    output var  int   high_b,  // Lower on-cycles
    output var  int   overlap  // Both-on cycles
);
    // Only on-time and overlap matter to a bridge, so plain integrators
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            high_a  <= 0;
            high_b  <= 0;
            overlap <= 0;
        end else begin
            high_a  <= high_a + int'(gate_a);
            high_b  <= high_b + int'(gate_b);
            overlap <= overlap + int'(gate_a && gate_b); // Shoot-through
        end
    end
endmodule // power_stage_model
`default_nettype wire

/* bench/sawtooth_oneshot_pulse_pwm_test.sv */
// Self-checking bench for the sawtooth one-shot pulse channel
`timescale 1ns/100ps
`default_nettype none
module sawtooth_oneshot_pulse_pwm_test;
    import oneshot_pwm_pkg::*;
    localparam logic [31:0] P = 32'hf; // Run-time period, 16 cycles
    logic clock, rst_n, count_start, count_stop, forced_transfer, period_wr, buffer_c_wr, buffer_d_wr;
    logic compare_b_wr, dead_time_enable, out_a_release_select, out_b_release_select;
    logic pin_mode_select_a, pin_mode_select_b, pwm_output_a, pwm_output_b;
    logic overflow_interrupt, compare_a_event, compare_b_event, counting;
    logic [31:0] period_wdata, buffer_c_wdata, buffer_d_wdata, compare_b_wdata;
    logic [31:0] dead_time_up_value, dead_time_down_value, channel_counter, compare_a, compare_b;
    logic [1:0]  out_a_force_duty, out_b_force_duty;
    logic [3:0]  out_a_io_function, out_b_io_function;
    int          high_a, high_b, overlap, n_mismatch, checks, cycles;

    // Small reset period so the run-time period write is visible
    sawtooth_oneshot_pulse_pwm #(.PERIOD_INIT(9)) sawtooth_oneshot_pulse_pwm_i (
        .clock, .rst_n, .count_start, .count_stop, .forced_transfer, .period_wr, .period_wdata,
        .buffer_c_wr, .buffer_c_wdata, .buffer_d_wr, .buffer_d_wdata, .compare_b_wr, .compare_b_wdata,
        .dead_time_enable, .dead_time_up_value, .dead_time_down_value, .out_a_force_duty,
        .out_b_force_duty, .out_a_release_select, .out_b_release_select, .out_a_io_function,
        .out_b_io_function, .pin_mode_select_a, .pin_mode_select_b, .pwm_output_a, .pwm_output_b,
        .overflow_interrupt, .compare_a_event, .compare_b_event, .counting, .channel_counter,
        .compare_a, .compare_b);
    power_stage_model power_stage_model_i (
        .clock, .rst_n, .gate_a(pwm_output_a), .gate_b(pwm_output_b), .high_a, .high_b, .overlap);

    // 20 MHz clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Bounded wait for a match pulse or an overflow pulse
    task automatic wait_on(input bit evt);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (n < 40 && (evt ? compare_a_event : overflow_interrupt) !== 1'b1);
        if ((evt ? compare_a_event : overflow_interrupt) !== 1'b1) check("wait", 0, 1);
    endtask

    task automatic set_buffers(input logic [31:0] c, input logic [31:0] d);
        buffer_c_wdata = c;
        buffer_d_wdata = d;
        {buffer_c_wr, buffer_d_wr} = 2'h3;
        @(negedge clock);
        {buffer_c_wr, buffer_d_wr} = 2'h0;
    endtask

    // One period, entered just after an overflow: loads next values like the
    // overflow handler, sets force codes mid-period, measures gate on-time
    task automatic period(input string name, input logic [31:0] c, input logic [31:0] d,
                          input logic [1:0] fa, input logic [1:0] fb, input int ea, input int eb);
        int sa, sb;
        sa = high_a;
        sb = high_b;
        set_buffers(c, d);
        repeat (4) @(negedge clock);
        out_a_force_duty = fa;
        out_b_force_duty = fb;
        wait_on(0);
        @(negedge clock);
        check({name, " a"}, high_a - sa, ea);
        check({name, " b"}, high_b - sb, eb);
    endtask

    task automatic t_reset();
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        check("counting", counting, 0);
        check("compare a", compare_a, 0);
        check("pins", {pwm_output_a, pwm_output_b}, 0);
        period_wdata = P;
        period_wr = 1'b1;
        @(negedge clock);
        period_wr = 1'b0;
        $display("test reset done");
    endtask

    task automatic t_preload_start();
        {dead_time_enable, out_a_release_select, out_b_release_select} = 3'h7;
        {pin_mode_select_a, pin_mode_select_b} = 2'h3;
        set_buffers(32'h4, 32'hc);
        forced_transfer = 1'b1;
        @(negedge clock);
        forced_transfer = 1'b0;
        check("preload a", compare_a, 32'h4);
        check("preload b", compare_b, 32'h3);
        set_buffers(32'h2, 32'hd);
        count_start = 1'b1;
        @(negedge clock);
        count_start = 1'b0;
        // Compare B at 3 matches one count before compare A at 4
        repeat (4) @(negedge clock);
        check("match b event", compare_b_event, 1);
        wait_on(1);
        check("match count", channel_counter, 32'h4);
        check("match a", compare_a, 32'hc);
        check("match b", compare_b, 32'hd);
        wait_on(0);
        check("load a", compare_a, 32'h2);
        check("load b", compare_b, 32'h1);
        @(negedge clock);
        $display("test preload_start done");
    endtask

    task automatic t_duty_sequence();
        period("partial", 32'h2, 32'hd, 2'h3, 2'h2, 11, 3);
        period("full", 32'h4, 32'hc, 2'h0, 2'h0, 16, 0);
        period("release high", 32'h4, 32'hc, 2'h2, 2'h3, 8, 6);
        period("zero", 32'h2, 32'hd, 2'h0, 2'h0, 0, 16);
        period("release low", 32'h2, 32'hd, 2'h0, 2'h0, 11, 3);
        check("overlap", overlap, 0);
        $display("test duty_sequence done");
    endtask

    task automatic t_stop_refuse();
        logic [31:0] held;
        count_stop = 1'b1;
        @(negedge clock);
        count_stop = 1'b0;
        repeat (2) @(negedge clock);
        held = channel_counter;
        repeat (4) @(negedge clock);
        check("stopped", counting, 0);
        check("held", channel_counter, held);
        held = compare_b;
        compare_b_wdata = 32'h9;
        compare_b_wr = 1'b1;
        @(negedge clock);
        check("refused", compare_b, held);
        dead_time_enable = 1'b0;
        compare_b_wdata = 32'h7;
        @(negedge clock);
        compare_b_wr = 1'b0;
        check("direct b", compare_b, 32'h7);
        $display("test stop_refuse done");
    endtask

    initial begin
        {clock, rst_n, count_start, count_stop, forced_transfer, period_wr, compare_b_wr} = '0;
        {buffer_c_wr, buffer_d_wr, dead_time_enable, pin_mode_select_a, pin_mode_select_b} = '0;
        {out_a_release_select, out_b_release_select, out_a_force_duty, out_b_force_duty} = '0;
        {period_wdata, buffer_c_wdata, buffer_d_wdata, compare_b_wdata} = '0;
        dead_time_up_value = 32'h1;
        dead_time_down_value = 32'h1;
        out_a_io_function = 4'h0; // Retain at cycle end
        out_b_io_function = 4'h0;
        {n_mismatch, checks, cycles} = '0;
        t_reset();
        t_preload_start();
        t_duty_sequence();
        t_stop_refuse();
        summarize();
    end
endmodule // sawtooth_oneshot_pulse_pwm_test
`default_nettype wire
